// ### logic/level_monitor_pkg.sv
package level_monitor_pkg;
	localparam int SAMPLE_W = 14;
	localparam int THRESH_W = 13;
	localparam int NUM_VC = 8;
	localparam int NUM_DDC = 4;
	localparam logic [11:0] ADDR_APP_MODE = 12'h200;
	localparam logic [11:0] ADDR_DECIMATION = 12'h201;
	localparam logic [11:0] ADDR_UPPER_LOW = 12'h247;
	localparam logic [11:0] ADDR_UPPER_HIGH = 12'h248;
	localparam logic [11:0] ADDR_LOWER_LOW = 12'h249;
	localparam logic [11:0] ADDR_LOWER_HIGH = 12'h24a;
	localparam logic [11:0] ADDR_DWELL_LOW = 12'h24b;
	localparam logic [11:0] ADDR_DWELL_HIGH = 12'h24c;
	localparam logic [11:0] ADDR_OVR_CLEAR = 12'h562;
	localparam logic [11:0] ADDR_OVR_STATUS = 12'h563;
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 4;
	localparam int Q_IGNORE_BIT = 5;
	localparam int DECIM_LSB = 0;
	localparam int DECIM_W = 4;
	localparam logic [7:0] RESET_APP_MODE = 8'h00;
	localparam logic [7:0] RESET_DECIMATION = 8'h01;
	localparam logic [15:0] RESET_UPPER = 16'h0fff;
	localparam logic [15:0] RESET_LOWER = 16'h0a1d;
	localparam logic [15:0] RESET_DWELL = 16'h0001;
	localparam logic [7:0] RESET_OVR_CLEAR = 8'h00;
	localparam logic [7:0] RESET_OVR_STATUS = 8'h00;
	localparam int CLK_HZ = 25_000_000;
	localparam int UPPER_LATENCY_MAX = 28;
	localparam int PIPE_DEPTH = 2;
	localparam int DEPTH_W = 3;
	localparam logic [DEPTH_W-1:0] PIPE_LEN = 3'h2;

	typedef enum logic [3:0] {
		MODE_FULL_BW = 4'b0000,
		MODE_ONE_DDC = 4'b0001,
		MODE_TWO_DDC = 4'b0010,
		MODE_FOUR_DDC = 4'b0011
	} app_mode_e;

	typedef struct packed {
		logic [SAMPLE_W-1:0] data;
		logic over;
		logic valid;
	} vc_sample_s;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
endpackage : level_monitor_pkg

// ### logic/sample_delay_line.sv
`timescale 1ns/1ps
// Equal-latency delay for sample plus its overrange flag
module sample_delay_line
	import level_monitor_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [SAMPLE_W:0] din_i,
	output logic [SAMPLE_W:0] dout_o
);
	logic [SAMPLE_W:0] stage [PIPE_DEPTH];

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < PIPE_DEPTH; i++)
				stage[i] <= '0;
		end
		else
		begin
			stage[0] <= din_i;
			for (int i = 1; i < PIPE_DEPTH; i++)
				stage[i] <= stage[i-1];
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			dout_o <= '0;
		else
			dout_o <= stage[PIPE_DEPTH-1];
	end
endmodule : sample_delay_line

// ### logic/overrange_fast_detect_mapper.sv
`timescale 1ns/1ps
module overrange_fast_detect_mapper
	import level_monitor_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [SAMPLE_W-1:0] sample_a_i,
	input wire logic [SAMPLE_W-1:0] sample_b_i,
	input wire logic over_a_i,
	input wire logic over_b_i,
	input wire logic [NUM_DDC-1:0][SAMPLE_W-1:0] ddc_i_i,
	input wire logic [NUM_DDC-1:0][SAMPLE_W-1:0] ddc_q_i,
	input wire logic [NUM_DDC-1:0] ddc_over_i,
	output logic level_alarm_out_a,
	output logic level_alarm_out_b,
	output logic [SAMPLE_W-1:0] sample_a_o,
	output logic [SAMPLE_W-1:0] sample_b_o,
	output logic over_ctrl_a_o,
	output logic over_ctrl_b_o,
	output vc_sample_s [NUM_VC-1:0] vc_o,
	output logic [3:0] app_mode_o,
	output logic q_ignore_o,
	output logic [3:0] decimation_o
);
	logic rst_sync1;
	logic rst_b;
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rst_sync1 <= 1'b0;
			rst_b <= 1'b0;
		end
		else
		begin
			rst_sync1 <= 1'b1;
			rst_b <= rst_sync1;
		end
	end

	reg_req_s req;
	assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

	logic [7:0] app_mode_reg;
	logic [7:0] decim_reg;
	logic [15:0] upper_thr;
	logic [15:0] lower_thr;
	logic [15:0] dwell_time;
	logic [7:0] ovr_clear;
	logic [7:0] ovr_status;

	always_ff @(posedge clk_i or negedge rst_b)
	begin
		if (!rst_b)
			upper_thr <= RESET_UPPER;
		else if (req.wr && req.addr == ADDR_UPPER_LOW)
			upper_thr[7:0] <= req.wdata;
		else if (req.wr && req.addr == ADDR_UPPER_HIGH)
			upper_thr[15:8] <= req.wdata;
	end

	always_ff @(posedge clk_i or negedge rst_b)
	begin
		if (!rst_b)
			lower_thr <= RESET_LOWER;
		else if (req.wr && req.addr == ADDR_LOWER_LOW)
			lower_thr[7:0] <= req.wdata;
		else if (req.wr && req.addr == ADDR_LOWER_HIGH)
			lower_thr[15:8] <= req.wdata;
	end

	always_ff @(posedge clk_i or negedge rst_b)
	begin
		if (!rst_b)
			dwell_time <= RESET_DWELL;
		else if (req.wr && req.addr == ADDR_DWELL_LOW)
			dwell_time[7:0] <= req.wdata;
		else if (req.wr && req.addr == ADDR_DWELL_HIGH)
			dwell_time[15:8] <= req.wdata;
	end

	always_ff @(posedge clk_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			app_mode_reg <= RESET_APP_MODE;
			decim_reg <= RESET_DECIMATION;
			ovr_clear <= RESET_OVR_CLEAR;
		end
		else if (req.wr)
		begin
			if (req.addr == ADDR_APP_MODE)
				app_mode_reg <= req.wdata;
			if (req.addr == ADDR_DECIMATION)
				decim_reg <= req.wdata;
			if (req.addr == ADDR_OVR_CLEAR)
				ovr_clear <= req.wdata;
		end
	end

	// Unused threshold bits read back as written; only 13 bits compare
	logic [7:0] next_rdata;
	always_comb
	begin
		next_rdata = 8'h00;
		case (req.addr)
			ADDR_APP_MODE: next_rdata = app_mode_reg;
			ADDR_DECIMATION: next_rdata = decim_reg;
			ADDR_UPPER_LOW: next_rdata = upper_thr[7:0];
			ADDR_UPPER_HIGH: next_rdata = upper_thr[15:8];
			ADDR_LOWER_LOW: next_rdata = lower_thr[7:0];
			ADDR_LOWER_HIGH: next_rdata = lower_thr[15:8];
			ADDR_DWELL_LOW: next_rdata = dwell_time[7:0];
			ADDR_DWELL_HIGH: next_rdata = dwell_time[15:8];
			ADDR_OVR_CLEAR: next_rdata = ovr_clear;
			ADDR_OVR_STATUS: next_rdata = ovr_status;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata_o <= 8'h00;
		else if (req.rd)
			reg_rdata_o <= next_rdata;
	end

	logic [THRESH_W-1:0] upper_cmp;
	logic [THRESH_W-1:0] lower_cmp;
	assign upper_cmp = upper_thr[THRESH_W-1:0];
	assign lower_cmp = lower_thr[THRESH_W-1:0];

	logic [1:0][SAMPLE_W-1:0] chan_in;
	logic [1:0] chan_over;
	logic [1:0][SAMPLE_W-1:0] chan_out;
	logic [1:0] chan_over_out;
	logic [1:0] alarm;
	assign chan_in[0] = sample_a_i;
	assign chan_in[1] = sample_b_i;
	assign chan_over[0] = over_a_i;
	assign chan_over[1] = over_b_i;

	for (genvar c = 0; c < 2; c++)
	begin : g_chan
		logic [THRESH_W-1:0] mag;
		logic [15:0] dwell_cnt;
		logic [SAMPLE_W-1:0] s;
		logic [SAMPLE_W-1:0] neg;
		logic [SAMPLE_W:0] dly_out;
		assign s = chan_in[c];
		assign neg = SAMPLE_W'(~s + 1'b1);
		// Most negative code saturates to full scale
		always_comb
		begin
			if (!s[SAMPLE_W-1])
				mag = s[THRESH_W-1:0];
			else if (neg[SAMPLE_W-1])
				mag = {THRESH_W{1'b1}};
			else
				mag = neg[THRESH_W-1:0];
		end

		always_ff @(posedge clk_i or negedge rst_b)
		begin
			if (!rst_b)
			begin
				alarm[c] <= 1'b0;
				dwell_cnt <= 16'h0000;
			end
			else if (mag > upper_cmp)
			begin
				alarm[c] <= 1'b1;
				dwell_cnt <= 16'h0000;
			end
			else if (alarm[c] && mag < lower_cmp)
			begin
				if (dwell_cnt >= dwell_time)
				begin
					alarm[c] <= 1'b0;
					dwell_cnt <= 16'h0000;
				end
				else
					dwell_cnt <= dwell_cnt + 16'h0001;
			end
			else
				dwell_cnt <= 16'h0000;
		end

		sample_delay_line u_dly (
			.clk_i(clk_i),
			.rst_b_i(rst_b),
			.din_i({chan_over[c], s}),
			.dout_o(dly_out)
		);
		assign chan_out[c] = dly_out[SAMPLE_W-1:0];
		assign chan_over_out[c] = dly_out[SAMPLE_W];
	end

	always_ff @(posedge clk_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			level_alarm_out_a <= 1'b0;
			level_alarm_out_b <= 1'b0;
		end
		else
		begin
			level_alarm_out_a <= alarm[0];
			level_alarm_out_b <= alarm[1];
		end
	end

	always_ff @(posedge clk_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sample_a_o <= '0;
			sample_b_o <= '0;
			over_ctrl_a_o <= 1'b0;
			over_ctrl_b_o <= 1'b0;
		end
		else
		begin
			sample_a_o <= chan_out[0];
			sample_b_o <= chan_out[1];
			over_ctrl_a_o <= chan_over_out[0];
			over_ctrl_b_o <= chan_over_out[1];
		end
	end

	app_mode_e mode;
	logic q_ignore;
	always_comb
	begin
		case (app_mode_reg[MODE_LSB +: MODE_W])
			4'b0001: mode = MODE_ONE_DDC;
			4'b0010: mode = MODE_TWO_DDC;
			4'b0011: mode = MODE_FOUR_DDC;
			default: mode = MODE_FULL_BW;
		endcase
	end
	assign q_ignore = app_mode_reg[Q_IGNORE_BIT];

	vc_sample_s [NUM_VC-1:0] next_vc;
	always_comb
	begin
		next_vc = '0;
		case (mode)
			MODE_FULL_BW:
			begin
				next_vc[0] = '{data: sample_a_i, over: over_a_i, valid: 1'b1};
				next_vc[1] = '{data: sample_b_i, over: over_b_i, valid: 1'b1};
			end
			MODE_ONE_DDC, MODE_TWO_DDC, MODE_FOUR_DDC:
			begin
				for (int d = 0; d < NUM_DDC; d++)
				begin
					if (d < (mode == MODE_ONE_DDC ? 1 : (mode == MODE_TWO_DDC ? 2 : 4)))
					begin
						if (q_ignore)
							next_vc[d] = '{data: ddc_i_i[d], over: ddc_over_i[d], valid: 1'b1};
						else
						begin
							next_vc[2*d] = '{data: ddc_i_i[d], over: ddc_over_i[d], valid: 1'b1};
							next_vc[2*d+1] = '{data: ddc_q_i[d], over: ddc_over_i[d], valid: 1'b1};
						end
					end
				end
			end
			default: next_vc = '0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b)
	begin
		if (!rst_b)
			vc_o <= '0;
		else
			vc_o <= next_vc;
	end

	always_ff @(posedge clk_i or negedge rst_b)
	begin
		if (!rst_b)
			ovr_status <= RESET_OVR_STATUS;
		else
			for (int v = 0; v < NUM_VC; v++)
				if (next_vc[v].valid && next_vc[v].over)
					ovr_status[v] <= 1'b1;
				else if (ovr_clear[v])
					ovr_status[v] <= 1'b0;
	end

	always_ff @(posedge clk_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			app_mode_o <= RESET_APP_MODE[3:0];
			q_ignore_o <= 1'b0;
			decimation_o <= RESET_DECIMATION[3:0];
		end
		else
		begin
			app_mode_o <= app_mode_reg[MODE_LSB +: MODE_W];
			q_ignore_o <= q_ignore;
			decimation_o <= decim_reg[DECIM_LSB +: DECIM_W];
		end
	end
endmodule : overrange_fast_detect_mapper

// ### tb/overrange_fast_detect_mapper_properties.sv
`timescale 1ns/1ps
module overrange_fast_detect_mapper_checker
	import level_monitor_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic [SAMPLE_W-1:0] sample_a_i,
	input wire logic [SAMPLE_W-1:0] sample_b_i,
	input wire logic over_a_i,
	input wire logic over_b_i,
	input wire logic level_alarm_out_a,
	input wire logic level_alarm_out_b,
	input wire logic [SAMPLE_W-1:0] sample_a_o,
	input wire logic [SAMPLE_W-1:0] sample_b_o,
	input wire logic over_ctrl_a_o,
	input wire logic over_ctrl_b_o,
	input wire vc_sample_s [NUM_VC-1:0] vc_o,
	input wire logic [3:0] app_mode_o,
	input wire logic q_ignore_o,
	input wire logic [3:0] decimation_o
);
	logic [15:0] up;
	logic [15:0] lo;
	logic [3:0] run;
	function automatic logic [12:0] mag(input logic [13:0] s);
		return s[13] ? ((s == 14'h2000) ? 13'h1fff : 13'(-s)) : s[12:0];
	endfunction : mag
	// Pipelines still hold reset contents for a few edges
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
			run <= 4'h0;
		else if (!run[3])
			run <= run + 4'h1;
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			up <= RESET_UPPER;
			lo <= RESET_LOWER;
		end
		else if (reg_wr_i)
			case (reg_addr_i)
				ADDR_UPPER_LOW: up[7:0] <= reg_wdata_i;
				ADDR_UPPER_HIGH: up[15:8] <= reg_wdata_i;
				ADDR_LOWER_LOW: lo[7:0] <= reg_wdata_i;
				ADDR_LOWER_HIGH: lo[15:8] <= reg_wdata_i;
				default: ;
			endcase
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	AST_TRIP_A: assert property (run[3] && mag(sample_a_i) > up[12:0] |-> ##[1:3] level_alarm_out_a)
		else $error("alarm a late");
	AST_TRIP_B: assert property (run[3] && mag(sample_b_i) > up[12:0] |-> ##[1:3] level_alarm_out_b)
		else $error("alarm b late");
	AST_FALL_A: assert property (run[3] && $fell(level_alarm_out_a) |-> $past(mag(sample_a_i), 3) < lo[12:0])
		else $error("alarm a fell early");
	AST_LAT_A: assert property (run[3] |-> {over_ctrl_a_o, sample_a_o} == $past({over_a_i, sample_a_i}, 4))
		else $error("path a latency");
	AST_LAT_B: assert property (run[3] |-> {over_ctrl_b_o, sample_b_o} == $past({over_b_i, sample_b_i}, 4))
		else $error("path b latency");
	AST_MODE: assert property (reg_wr_i && reg_addr_i == ADDR_APP_MODE
		|-> ##2 {q_ignore_o, app_mode_o} == $past({reg_wdata_i[5], reg_wdata_i[3:0]}, 2))
		else $error("mode field");
	AST_DECIM: assert property (reg_wr_i && reg_addr_i == ADDR_DECIMATION
		|-> ##2 decimation_o == $past(reg_wdata_i[3:0], 2))
		else $error("decimation field");
	AST_UNUSED: assert property (run[3] && $stable({app_mode_o, q_ignore_o}) && app_mode_o == MODE_ONE_DDC
		&& q_ignore_o |-> vc_o[7:1] == '0)
		else $error("unused converter busy");
endmodule : overrange_fast_detect_mapper_checker
bind overrange_fast_detect_mapper overrange_fast_detect_mapper_checker i_chk (.*);

// ### tb/gain_link_partner.sv
`timescale 1ns/1ps
// Gain control counts alarm onsets; link side keeps control bits seen
module gain_link_partner
	import level_monitor_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic alarm_a_i,
	input wire logic alarm_b_i,
	input wire vc_sample_s [NUM_VC-1:0] vc_i,
	output logic [7:0] steps_o,
	output logic [NUM_VC-1:0] ctrl_o
);
	logic [1:0] last;
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			last <= 2'h0;
			steps_o <= 8'h00;
			ctrl_o <= '0;
		end
		else
		begin
			last <= {alarm_b_i, alarm_a_i};
			steps_o <= steps_o + 8'(alarm_a_i & ~last[0]) + 8'(alarm_b_i & ~last[1]);
			for (int k = 0; k < NUM_VC; k++)
				if (vc_i[k].valid && vc_i[k].over)
					ctrl_o[k] <= 1'b1;
		end
endmodule : gain_link_partner

// ### tb/overrange_fast_detect_mapper_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			errors++; \
			$display("wrong value t=%0t got %h exp %h", $time, got, exp); \
		end \
	end
module overrange_fast_detect_mapper_tb
	import level_monitor_pkg::*;
;
	logic clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, over_a_i = 1'b0, over_b_i = 1'b0;
	logic [11:0] reg_addr_i = '0;
	logic [7:0] reg_wdata_i = '0, reg_rdata_o, steps;
	logic [SAMPLE_W-1:0] sample_a_i = '0, sample_b_i = '0, sample_a_o, sample_b_o;
	logic [NUM_DDC-1:0][SAMPLE_W-1:0] ddc_i_i = {14'h0103, 14'h0102, 14'h0101, 14'h0100};
	logic [NUM_DDC-1:0][SAMPLE_W-1:0] ddc_q_i = {14'h0203, 14'h0202, 14'h0201, 14'h0200};
	logic [NUM_DDC-1:0] ddc_over_i = '0;
	logic level_alarm_out_a, level_alarm_out_b, over_ctrl_a_o, over_ctrl_b_o, q_ignore_o;
	vc_sample_s [NUM_VC-1:0] vc_o;
	logic [3:0] app_mode_o, decimation_o;
	logic [NUM_VC-1:0] ctrl;
	int errors = 0, n_checks = 0;
	overrange_fast_detect_mapper i_dut (.*);
	gain_link_partner i_far (.clk_i(clk_i), .rst_b_i(rst_b_i), .alarm_a_i(level_alarm_out_a),
		.alarm_b_i(level_alarm_out_b), .vc_i(vc_o), .steps_o(steps), .ctrl_o(ctrl));
	always #20 clk_i = ~clk_i;
	task automatic end_sim;
		$display("errors=%0d checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim
	task automatic step(input int n);
		repeat (n) @(negedge clk_i);
	endtask : step
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		`CHK(reg_rdata_o, e)
	endtask : rd
	initial
	begin
		#200_000;
		errors++;
		end_sim();
	end
	initial
	begin
		static logic [11:0] ra [10] = '{ADDR_APP_MODE, ADDR_DECIMATION, ADDR_UPPER_LOW, ADDR_UPPER_HIGH, ADDR_LOWER_LOW,
			ADDR_LOWER_HIGH, ADDR_DWELL_LOW, ADDR_DWELL_HIGH, ADDR_OVR_CLEAR, ADDR_OVR_STATUS};
		static logic [7:0] rv [10] = '{8'h00, 8'h01, 8'hff, 8'h0f, 8'h1d, 8'h0a, 8'h01, 8'h00, 8'h00, 8'h00};
		static logic [3:0] md [7] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3};
		static logic [6:0] qi = 7'b0101010;
		vc_sample_s ev;
		int nd;
		repeat (6) @(posedge clk_i);
		step(1);
		rst_b_i = 1'b1;
		step(3);
		for (int i = 0; i < 10; i++)
			rd(ra[i], rv[i]);
		rd(12'h300, 8'h00);
		// Upper 0x100, lower 0x80, dwell 3
		wr(ADDR_UPPER_LOW, 8'h00);
		wr(ADDR_UPPER_HIGH, 8'h01);
		wr(ADDR_LOWER_LOW, 8'h80);
		wr(ADDR_LOWER_HIGH, 8'h00);
		wr(ADDR_DWELL_LOW, 8'h03);
		rd(ADDR_DWELL_LOW, 8'h03);
		rd(ADDR_UPPER_HIGH, 8'h01);
		rd(ADDR_LOWER_LOW, 8'h80);
		sample_a_i = 14'h0101;
		step(4);
		`CHK({level_alarm_out_a, level_alarm_out_b}, 2'b10)
		sample_a_i = 14'h0090;
		step(10);
		`CHK(level_alarm_out_a, 1'b1)
		sample_a_i = 14'h0010;
		step(2);
		sample_a_i = 14'h0090;
		step(6);
		`CHK(level_alarm_out_a, 1'b1)
		sample_a_i = 14'h0010;
		step(8);
		`CHK(level_alarm_out_a, 1'b0)
		sample_b_i = 14'h3eff;
		step(4);
		`CHK(level_alarm_out_b, 1'b1)
		sample_b_i = 14'h0022;
		step(8);
		`CHK({level_alarm_out_b, steps}, {1'b0, 8'h02})
		over_a_i = 1'b1;
		step(1);
		over_a_i = 1'b0;
		step(3);
		// Flag leaves with its own sample four edges later
		`CHK({over_ctrl_a_o, sample_a_o}, {1'b1, 14'h0010})
		step(1);
		`CHK(over_ctrl_a_o, 1'b0)
		step(2);
		rd(ADDR_OVR_STATUS, 8'h01);
		wr(ADDR_DECIMATION, 8'h04);
		step(2);
		`CHK(decimation_o, 4'h4)
		for (int r = 0; r < 7; r++)
		begin
			wr(ADDR_APP_MODE, {2'h0, qi[r], 1'b0, md[r]});
			step(4);
			`CHK({q_ignore_o, app_mode_o}, {qi[r], md[r]})
			nd = (md[r] == 4'h3) ? 4 : int'(md[r]);
			for (int k = 0; k < NUM_VC; k++)
			begin
				ev = '0;
				if (md[r] == 4'h0 && k < 2)
					ev = '{k ? sample_b_i : sample_a_i, 1'b0, 1'b1};
				else if (qi[r] && k < nd)
					ev = '{ddc_i_i[k], 1'b0, 1'b1};
				else if (!qi[r] && k < 2 * nd)
					ev = '{k[0] ? ddc_q_i[k/2] : ddc_i_i[k/2], 1'b0, 1'b1};
				`CHK(vc_o[k], ev)
			end
		end
		ddc_over_i = 4'hf;
		step(1);
		ddc_over_i = 4'h0;
		step(4);
		`CHK(ctrl, 8'hff)
		rd(ADDR_OVR_STATUS, 8'hff);
		wr(ADDR_OVR_CLEAR, 8'hff);
		wr(ADDR_OVR_CLEAR, 8'h00);
		wr(ADDR_OVR_STATUS, 8'hff);
		rd(ADDR_OVR_STATUS, 8'h00);
		ddc_over_i = 4'h1;
		step(1);
		ddc_over_i = 4'h0;
		rd(ADDR_OVR_STATUS, 8'h03);
		// Mid-run reset must drop sticky bits and config
		rst_b_i = 1'b0;
		step(2);
		rst_b_i = 1'b1;
		step(3);
		rd(ADDR_OVR_STATUS, RESET_OVR_STATUS);
		`CHK(decimation_o, RESET_DECIMATION[3:0])
		end_sim();
	end
endmodule : overrange_fast_detect_mapper_tb
